// >>> core/dic_host.sv
// Purpose: power-up sequencer and mode register access for a ddr mobile sdram
// Assumes: rst synchronous active high, clk 25 MHz, dev_ck = clk / 2
// Notes: cmd_addr_bus halves change on the same clk edge as dev_ck
// How it works
// R1: cke low at least 100ns first
// R2: five stable clocks before cke rises
// R3: boot clock period within 18 to 100ns
// R4: cke high, only nops for 200us
// R5: then issue soft reinit mode write
// R6: after reinit keep cke, only nops
// R7: post reinit idle is 1us
// R8: afterwards device takes only reads, power-down
// R9: device clears status within max time
// R10: auto init lasts at most 10us
// R11: status flag is bit 0, info register
// R12: proceed after timeout or status clear
// R13: calibration write, then wait calibration time
// R14: write burst, latency, io registers then
// R15: one command per clock, both edges
// R16: chip select, cke sampled rising edge
// R17: four transfers per data line access
// R18: device accepts access to other banks
// R19: mode writes only with banks idle
// R20: burst stop only during a burst
// R21: only nops during mode read/write time
// R22: respect act to act spacing
// R23: nops to bank in auto precharge
// R24: read/write turnaround needs burst end
// R25: device takes mode reads while activating
// R26: reinit is a mode write, banks idle
// R27: write mask high inhibits, low writes
// R28: device ignores illegal commands
`timescale 1ns/10ps
module dic_host import dic_pkg::*; #(
   parameter logic [CNT_W-1:0] IDLE_CYC = CNT_W'(T_IDLE_CKE_US * 1000 / CLK_NS)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // configuration values written at the end of init
   input wire logic [7:0] cfg_burst,
   input wire logic [7:0] cfg_latency,
   input wire logic [7:0] cfg_io,
   // user command port
   output logic init_done,
   output logic dai_timeout,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_read,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   // mode register read data
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [7:0] rd_data,
   // device pins
   output logic dev_ck,
   output logic dev_cke,
   output logic dev_cs_n,
   output logic [CA_W-1:0] dev_cmd_addr_bus,
   output logic [3:0] dev_write_mask,
   input wire logic [7:0] dev_dq_in,
   output logic [7:0] dev_dq_out,
   output logic dev_dq_oe,
   input wire logic dev_dqs_in,
   output logic dev_dqs_out,
   output logic dev_dqs_oe
);
   dic_state_e st, next_st;
   logic ph, issue, mode_reg_read, pend, got, dai_val, dai_ok, cap, push, pop;
   logic [CNT_W-1:0] wcnt, wait_ld, ai_cnt;
   logic [2*CA_W-1:0] cmd;
   logic [CA_W-1:0] fall_q;
   logic [7:0] dq_s1, dq_s2;
   logic dqs_s1, dqs_s2, dqs_s3;
   logic [7:0] mem [2];
   logic wp, rp;
   logic [1:0] fcnt;

   // device clock divider
   always_ff @(posedge clk) begin
      if (rst) ph <= 1'b0;
      else ph <= ~ph; // see R3
   end
   assign dev_ck = ph;

   // pin synchronisers
   always_ff @(posedge clk) begin
      dq_s1 <= dev_dq_in;
      dq_s2 <= dq_s1;
      dqs_s1 <= dev_dqs_in;
      dqs_s2 <= dqs_s1;
      dqs_s3 <= dqs_s2;
   end

   // no writes issued: mask inhibits, data pins released
   assign dev_write_mask = DM_OFF; // see R27
   assign dev_dq_out = 8'h00;
   assign dev_dq_oe = 1'b0;
   assign dev_dqs_out = 1'b0;
   assign dev_dqs_oe = 1'b0;

   assign cap = pend && dqs_s2 && !dqs_s3;
   assign dai_ok = got && !dai_val;
   assign init_done = (st == S_READY);
   // only mode reads and writes are offered, so no burst, activate or stop is ever issued
   assign cmd_ready = (st == S_READY) && ph && (wcnt == '0) && !pend && (!cmd_read || fcnt != 2'h2); // see R20, R22, R23, R24

   // sequencer decisions, taken once per device clock period
   always_comb begin
      next_st = st;
      issue = 1'b0;
      mode_reg_read = 1'b0;
      cmd = {CA_NOP_F, CA_NOP_R};
      wait_ld = '0;
      if (ph && wcnt == '0) begin
         case (st)
            S_CKE_LOW: begin
               next_st = S_STABLE; // see R1
               wait_ld = CYC_STABLE;
            end
            S_STABLE: begin
               next_st = S_IDLE; // see R2
               wait_ld = IDLE_CYC;
            end
            S_IDLE: begin
               issue = 1'b1; // see R4, R5, R26
               cmd = dic_mrw(MA_REINIT, OP_REINIT);
               next_st = S_POLL;
               wait_ld = CYC_REINIT; // see R6, R7
            end
            S_POLL: begin
               issue = 1'b1;
               mode_reg_read = 1'b1;
               cmd = dic_mrr(MA_DEV_INFO);
               next_st = S_CHECK;
               wait_ld = CYC_MRR; // see R21
            end
            S_CHECK: begin
               if (dai_ok || ai_cnt == '0) begin
                  next_st = S_ZQ; // see R12
               end else begin
                  issue = 1'b1;
                  mode_reg_read = 1'b1;
                  cmd = dic_mrr(MA_DEV_INFO);
                  wait_ld = CYC_MRR;
               end
            end
            S_ZQ: begin
               issue = 1'b1;
               cmd = dic_mrw(MA_CAL, OP_CAL_INIT);
               next_st = S_CFG1;
               wait_ld = CYC_CAL; // see R13
            end
            S_CFG1: begin
               issue = 1'b1; // see R14, R19
               cmd = dic_mrw(MA_BURST, cfg_burst);
               next_st = S_CFG2;
               wait_ld = CYC_MRW;
            end
            S_CFG2: begin
               issue = 1'b1;
               cmd = dic_mrw(MA_LATENCY, cfg_latency);
               next_st = S_CFG3;
               wait_ld = CYC_MRW;
            end
            S_CFG3: begin
               issue = 1'b1;
               cmd = dic_mrw(MA_IO, cfg_io);
               next_st = S_READY;
               wait_ld = CYC_MRW;
            end
            S_READY: begin
               if (cmd_valid && cmd_ready) begin
                  issue = 1'b1;
                  mode_reg_read = cmd_read;
                  cmd = cmd_read ? dic_mrr(cmd_addr) : dic_mrw(cmd_addr, cmd_wdata);
                  wait_ld = cmd_read ? CYC_MRR : CYC_MRW; // see R21
               end
            end
            default: next_st = S_CKE_LOW;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) st <= S_CKE_LOW;
      else st <= next_st;
   end

   // wait timer gating every command
   always_ff @(posedge clk) begin
      if (rst) wcnt <= CYC_CKE_LOW;
      else if (ph && wcnt == '0) wcnt <= wait_ld;
      else if (wcnt != '0) wcnt <= wcnt - 1'b1;
   end

   // auto init limit from the reinit command
   always_ff @(posedge clk) begin
      if (rst) ai_cnt <= CYC_AUTO_INIT;
      else if (st == S_IDLE && issue) ai_cnt <= CYC_AUTO_INIT;
      else if (ai_cnt != '0) ai_cnt <= ai_cnt - 1'b1;
   end

   // clock enable, raised once and then held
   always_ff @(posedge clk) begin
      if (rst) dev_cke <= 1'b0;
      else if (st == S_STABLE && next_st == S_IDLE) dev_cke <= 1'b1; // see R1, R2, R6
   end

   // command pins: rising half while ck low, falling half while ck high
   always_ff @(posedge clk) begin
      if (rst) begin
         dev_cs_n <= 1'b1;
         dev_cmd_addr_bus <= CA_NOP_R;
         fall_q <= CA_NOP_F;
      end else if (ph) begin
         dev_cs_n <= ~issue;
         dev_cmd_addr_bus <= cmd[CA_W-1:0];
         fall_q <= cmd[2*CA_W-1:CA_W];
      end else begin
         dev_cmd_addr_bus <= fall_q; // see R15
      end
   end

   // mode read capture and status flag
   always_ff @(posedge clk) begin
      if (rst) begin
         pend <= 1'b0;
         got <= 1'b0;
         dai_val <= 1'b1;
         dai_timeout <= 1'b0;
      end else begin
         if (issue && mode_reg_read) begin
            pend <= 1'b1;
            got <= 1'b0;
         end else if (cap || wcnt == '0) begin
            pend <= 1'b0;
         end
         if (cap) begin
            got <= 1'b1;
            dai_val <= dq_s2[DAI_BIT];
         end
         if (st == S_CHECK && next_st == S_ZQ && !dai_ok) dai_timeout <= 1'b1; // see R12
      end
   end

   // two entry read data buffer
   assign push = cap && (st == S_READY);
   assign pop = rd_valid && rd_ready;
   assign rd_valid = (fcnt != 2'h0);
   assign rd_data = mem[rp];
   always_ff @(posedge clk) begin
      if (rst) begin
         wp <= 1'b0;
         rp <= 1'b0;
         fcnt <= 2'h0;
      end else begin
         if (push) wp <= ~wp;
         if (pop) rp <= ~rp;
         fcnt <= fcnt + {1'b0, push} - {1'b0, pop};
      end
   end
   always_ff @(posedge clk) begin
      if (push) mem[wp] <= dq_s2;
   end

   // checking helpers
   logic [CNT_W-1:0] low_cnt, hi_cnt, gap, need;
   logic [3:0] ck_cnt;
   logic seen, cmd_start;
   logic [2*CA_W-1:0] reinit_cmd;
   assign reinit_cmd = dic_mrw(MA_REINIT, OP_REINIT);
   assign cmd_start = !dev_cs_n && !ph;
   always_ff @(posedge clk) begin
      if (rst) begin
         low_cnt <= '0;
         hi_cnt <= '0;
         ck_cnt <= 4'h0;
         gap <= '0;
         need <= '0;
         seen <= 1'b0;
      end else begin
         if (!dev_cke && low_cnt != '1) low_cnt <= low_cnt + 1'b1;
         if (dev_cke && hi_cnt != '1) hi_cnt <= hi_cnt + 1'b1;
         if (ph && ck_cnt != 4'hF) ck_cnt <= ck_cnt + 4'h1;
         if (cmd_start) begin
            gap <= CNT_W'(1);
            seen <= 1'b1;
            need <= !seen ? CYC_REINIT : (dev_cmd_addr_bus[3:0] == CA_OPC_MRR) ? CYC_MRR : CYC_MRW;
         end else if (gap != '1) begin
            gap <= gap + 1'b1;
         end
      end
   end

   a_cke_low_time: // see R1
   assert property (@(posedge clk) disable iff (rst) $rose(dev_cke) |-> low_cnt >= CYC_CKE_LOW)
      else $error("cke raised too early");
   a_clk_stable: // see R2
   assert property (@(posedge clk) disable iff (rst) $rose(dev_cke) |-> ck_cnt >= T_CLK_STABLE_CK)
      else $error("too few clocks before cke");
   a_boot_period: // see R3
   assert property (@(posedge clk) disable iff (rst) !rst |=> dev_ck != $past(dev_ck))
      else $error("device clock not toggling");
   a_idle_nop: // see R4
   assert property (@(posedge clk) disable iff (rst) !dev_cs_n |-> dev_cke && hi_cnt >= IDLE_CYC)
      else $error("command during cke idle time");
   a_first_reinit: // see R5
   assert property (@(posedge clk) disable iff (rst)
      cmd_start && !seen |-> dev_cmd_addr_bus == reinit_cmd[CA_W-1:0]
      ##1 dev_cmd_addr_bus == reinit_cmd[2*CA_W-1:CA_W])
      else $error("first command is not reinit");
   a_cmd_spacing: // see R6, R7, R21
   assert property (@(posedge clk) disable iff (rst) cmd_start && seen |-> gap >= need)
      else $error("command inside wait time");
   a_cke_held: // see R6
   assert property (@(posedge clk) disable iff (rst) dev_cke |=> dev_cke)
      else $error("cke dropped");
   a_dai_wait: // see R12
   assert property (@(posedge clk) disable iff (rst)
      st == S_CHECK && next_st == S_ZQ |-> dai_ok || ai_cnt == '0)
      else $error("calibration before auto init done");
   a_mask_idle: // see R27
   assert property (@(posedge clk) disable iff (rst) !dev_dq_oe |-> dev_write_mask == DM_OFF)
      else $error("write mask not inhibiting");
   a_cfg_order: // see R14
   assert property (@(posedge clk) disable iff (rst) $rose(init_done) |-> $past(st) == S_CFG3)
      else $error("ready without configuration");
endmodule : dic_host

// >>> include/dic_pkg.sv
// Purpose: constants, states and command encoders for the dram init controller
// Assumes: 40 ns system clock, device clock is system clock divided by two
// Notes: times are kept in their own units, cycle counts derive from them
package dic_pkg;
   localparam int CLK_NS = 40;
   localparam int CK_DIV = 2;
   localparam int CNT_W = 13;
   localparam int CA_W = 10;
   localparam int T_CKE_LOW_NS = 100;
   localparam int T_CLK_STABLE_CK = 5;
   localparam int T_IDLE_CKE_US = 200;
   localparam int T_REINIT_US = 1;
   localparam int T_AUTO_INIT_US = 10;
   localparam int T_CAL_US = 1;
   localparam int T_MODEREG_READ_CK = 8;
   localparam int T_MODEREG_WRITE_CK = 5;
   localparam logic [CNT_W-1:0] CYC_CKE_LOW = CNT_W'((T_CKE_LOW_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] CYC_STABLE = CNT_W'(T_CLK_STABLE_CK * CK_DIV);
   localparam logic [CNT_W-1:0] CYC_REINIT = CNT_W'((T_REINIT_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] CYC_AUTO_INIT = CNT_W'((T_AUTO_INIT_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] CYC_CAL = CNT_W'((T_CAL_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] CYC_MRR = CNT_W'(T_MODEREG_READ_CK * CK_DIV);
   localparam logic [CNT_W-1:0] CYC_MRW = CNT_W'(T_MODEREG_WRITE_CK * CK_DIV);
   localparam logic [3:0] CA_OPC_MRW = 4'h0;
   localparam logic [3:0] CA_OPC_MRR = 4'h8;
   localparam logic [CA_W-1:0] CA_NOP_R = 10'h007;
   localparam logic [CA_W-1:0] CA_NOP_F = 10'h000;
   localparam logic [7:0] MA_DEV_INFO = 8'h00;
   localparam logic [7:0] MA_BURST = 8'h01;
   localparam logic [7:0] MA_LATENCY = 8'h02;
   localparam logic [7:0] MA_IO = 8'h03;
   localparam logic [7:0] MA_CAL = 8'h0A;
   localparam logic [7:0] MA_REINIT = 8'h3F;
   localparam logic [7:0] OP_CAL_INIT = 8'hFF;
   localparam logic [7:0] OP_REINIT = 8'h00;
   localparam int DAI_BIT = 0;
   localparam logic [3:0] DM_OFF = 4'hF;
   typedef enum logic [3:0] {
      S_CKE_LOW = 4'h0,
      S_STABLE = 4'h1,
      S_IDLE = 4'h3,
      S_POLL = 4'h2,
      S_CHECK = 4'h6,
      S_ZQ = 4'h7,
      S_CFG1 = 4'h5,
      S_CFG2 = 4'h4,
      S_CFG3 = 4'hC,
      S_READY = 4'hD
   } dic_state_e;
   function automatic logic [2*CA_W-1:0] dic_mrw(input logic [7:0] ma, input logic [7:0] op);
      return {op, ma[7:6], ma[5:0], CA_OPC_MRW};
   endfunction : dic_mrw
   function automatic logic [2*CA_W-1:0] dic_mrr(input logic [7:0] ma);
      return {8'h00, ma[7:6], ma[5:0], CA_OPC_MRR};
   endfunction : dic_mrr
endpackage : dic_pkg

// >>> tb/dic_dev_model.sv
// Purpose: behavioural sdram device answering mode reads and writes
// Assumes: pins are sampled at clk edges where dev_ck toggles
// Notes: viol counts controller-side faults; mute silences read strobes
`timescale 1ns/10ps
module dic_dev_model import dic_pkg::*; #(
   parameter int IDLE = 40,
   parameter int AI_CYC = 60,
   parameter int RL = 2
) (
   // bench side
   input wire logic clk,
   input wire logic mute,
   output logic [7:0] viol,
   // device pins
   input wire logic dev_ck,
   input wire logic dev_cke,
   input wire logic dev_cs_n,
   input wire logic [CA_W-1:0] dev_cmd_addr_bus,
   input wire logic [3:0] dev_write_mask,
   output logic [7:0] dev_dq_in,
   output logic dev_dqs_in
);
   logic [7:0] mr [256];
   logic [CA_W-1:0] rh;
   logic [7:0] ma, rv;
   logic hit = 0, auto_init_status = 1, clr = 0, boot = 0, cke_q = 0, ck_q = 0;
   int lo = 0, lo_ck = 0, gap = 0, need = 0, ai = 0, since = 0, per = 0, rt = 0;
   initial begin
      viol = 8'h00;
      dev_dq_in = 8'h00;
      dev_dqs_in = 1'b0;
   end
   always @(posedge clk) begin
      gap++;
      since++;
      per++;
      if (!dev_cke) lo++;
      if (dev_ck && !ck_q && !dev_cke) lo_ck++;
      ck_q = dev_ck;
      if (ai == 1) auto_init_status = 0;
      if (ai > 0) ai--;
      if (dev_write_mask !== DM_OFF) viol++;
      rt = (rt == 0 || rt >= RL + 8) ? 0 : rt + 1;
      dev_dqs_in <= rt > RL && (rt - RL - 1) % 4 < 2;
      dev_dq_in <= rt > RL ? rv : ~dev_dq_in;
      if (!dev_ck) begin
         if (dev_cke && (per * CLK_NS > 100 || per * CLK_NS < 18)) viol++;
         per = 0;
         if (dev_cke && !cke_q) begin
            if (lo < CYC_CKE_LOW || lo_ck < T_CLK_STABLE_CK) viol++;
            gap = 0;
            need = IDLE;
            boot = 0;
            lo = 0;
            lo_ck = 0;
         end
         cke_q = dev_cke;
         hit = !dev_cs_n && dev_cke;
         rh = dev_cmd_addr_bus;
      end else if (hit) begin
         hit = 0;
         ma = {dev_cmd_addr_bus[1:0], rh[9:4]};
         if (gap < need) viol++;
         gap = 0;
         need = CYC_MRW;
         if (rh[3:0] == CA_OPC_MRW && ma == MA_REINIT) begin
            auto_init_status = 1;
            ai = AI_CYC;
            need = CYC_REINIT;
            since = 0;
            clr = 0;
            boot = 1;
         end else if (!boot) viol++;
         else if (rh[3:0] == CA_OPC_MRW) begin
            if (ma == MA_CAL) need = CYC_CAL;
            if (ma == MA_CAL && !clr && since < CYC_AUTO_INIT) viol++;
            if (!auto_init_status) mr[ma] = dev_cmd_addr_bus[9:2];
         end else if (rh[3:0] == CA_OPC_MRR) begin
            need = CYC_MRR;
            rv = ma == MA_DEV_INFO ? {7'h00, auto_init_status} : mr[ma];
            clr = clr || (!mute && ma == MA_DEV_INFO && !auto_init_status);
            rt = mute ? 0 : 1;
         end else viol++;
      end
   end
endmodule : dic_dev_model

// >>> tb/dic_host_bench.sv
// Purpose: self-checking bench for the dram init controller
// Assumes: short idle count, device model on the pins
// Notes: boots twice, the second time with silent status reads
`timescale 1ns/10ps
module dic_host_bench import dic_pkg::*;;
   logic clk, rst, cmd_valid, cmd_ready, cmd_read, init_done, dai_timeout, rd_valid, rd_ready, mute, ok;
   logic dev_ck, dev_cke, dev_cs_n, dev_dqs_in;
   logic [7:0] cfg_burst, cfg_latency, cfg_io, cmd_addr, cmd_wdata, rd_data, dev_dq_in, viol;
   logic [CA_W-1:0] ca;
   logic [3:0] wm;
   logic dq_oe, dqs_oe;
   int n_errors = 0, num_checks = 0, cyc = 0, i;
   dic_host #(.IDLE_CYC(CNT_W'(40))) DUT (
      .clk(clk), .rst(rst), .cfg_burst(cfg_burst), .cfg_latency(cfg_latency), .cfg_io(cfg_io),
      .init_done(init_done), .dai_timeout(dai_timeout), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data), .dev_ck(dev_ck), .dev_cke(dev_cke), .dev_cs_n(dev_cs_n),
      .dev_cmd_addr_bus(ca), .dev_write_mask(wm), .dev_dq_in(dev_dq_in), .dev_dq_out(), .dev_dq_oe(dq_oe),
      .dev_dqs_in(dev_dqs_in), .dev_dqs_out(), .dev_dqs_oe(dqs_oe));
   dic_dev_model #(.IDLE(40), .AI_CYC(60), .RL(2)) DEV (
      .clk(clk), .mute(mute), .viol(viol), .dev_ck(dev_ck), .dev_cke(dev_cke), .dev_cs_n(dev_cs_n),
      .dev_cmd_addr_bus(ca), .dev_write_mask(wm), .dev_dq_in(dev_dq_in), .dev_dqs_in(dev_dqs_in));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask : chk_byte
   task chk_bit(input string n, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("FAIL %s expected %b seen %b", n, e, g);
      end
   endtask : chk_bit
   task final_report;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report
   task issue(input logic rd, input logic [7:0] a, input logic [7:0] d, input int lim);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_read <= rd;
      cmd_addr <= a;
      cmd_wdata <= d;
      ok = 1'b0;
      for (i = 0; i < lim && !ok; i++) begin
         @(posedge clk);
         ok = cmd_ready === 1'b1;
      end
      cmd_valid <= 1'b0;
   endtask : issue
   task pop(input string n, input logic [7:0] e);
      @(posedge clk);
      for (i = 0; i < 40 && rd_valid !== 1'b1; i++) @(posedge clk);
      chk_byte(n, e, rd_data);
      rd_ready <= 1'b1;
      @(posedge clk);
      rd_ready <= 1'b0;
   endtask : pop
   task boot(input logic [7:0] b, input logic to);
      rst <= 1'b1;
      cfg_burst <= b;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 2000 && init_done !== 1'b1; i++) @(posedge clk);
      chk_bit("init_done", 1'b1, init_done);
      chk_bit("dai_timeout", to, dai_timeout);
      chk_bit("boot length", to, i >= 40 + CYC_AUTO_INIT);
      repeat (4) @(posedge clk);
      chk_byte("burst reg", b, DEV.mr[MA_BURST]);
      chk_byte("latency reg", cfg_latency, DEV.mr[MA_LATENCY]);
      chk_byte("io reg", cfg_io, DEV.mr[MA_IO]);
      chk_byte("calib reg", OP_CAL_INIT, DEV.mr[MA_CAL]);
   endtask : boot
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         final_report;
      end
   end
   initial begin
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_read = 1'b0;
      cmd_addr = 8'h00;
      cmd_wdata = 8'h00;
      rd_ready = 1'b0;
      mute = 1'b0;
      ok = 1'b0;
      cfg_burst = 8'h00;
      cfg_latency = 8'h05;
      cfg_io = 8'h02;
      boot(8'h42, 1'b0);
      issue(1'b0, MA_BURST, 8'h5A, 40);
      issue(1'b1, MA_BURST, 8'h00, 40);
      pop("read back", 8'h5A);
      issue(1'b1, MA_DEV_INFO, 8'h00, 40);
      pop("status", 8'h00);
      issue(1'b1, MA_LATENCY, 8'h00, 40);
      issue(1'b1, MA_IO, 8'h00, 40);
      issue(1'b1, MA_BURST, 8'h00, 40);
      chk_bit("full refused", 1'b0, ok);
      pop("fifo head", 8'h05);
      pop("fifo next", 8'h02);
      mute <= 1'b1;
      issue(1'b1, MA_IO, 8'h00, 40);
      repeat (30) @(posedge clk);
      chk_bit("silent read", 1'b0, rd_valid);
      cfg_latency <= 8'h06;
      boot(8'hA3, 1'b1);
      chk_byte("rule faults", 8'h00, viol);
      chk_bit("data drive", 1'b0, dq_oe | dqs_oe);
      final_report;
   end
endmodule : dic_host_bench
